/* rtl/wdr_top.sv */
// wdr_top: watchdog timer with reset-cause flags and internal reset sequencer
// assumes instruction strobes and reset-cause events arrive as one-cycle pulses
// synchronous to i_clock; the reset pulse classification is done outside
//
// Operation
// - watchdog runs after reset; disable only before end-of-init
// - overflow starts internal reset, pulls reset-out low
// - 16-bit counter advances on clock divided 2/128
// - bit 0 selects divide by 2 or 128
// - bits 15:8 hold the high-byte reload value
// - service loads counter high byte from reload
// - timeout is 512*(1+63*presc)*(256-reload) clocks
// - power-on flag bit 5, cleared by end-of-init
// - long reset flag bit 4, cleared by end-of-init
// - short reset flag bit 3, cleared by end-of-init
// - soft reset flag bit 2, cleared by end-of-init
// - overflow flag bit 1, cleared by hw reset/service
// - software writes never change flags 5:1
// - each reset source sets its documented flag group
// - power-on flag only after core supply fell low
// - bidir reset with pin low promotes to long
`timescale 1ns/100ps
module wdr_top
  import wdr_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_sys_rst,
  // register port
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // cpu instruction strobes
  input  wire logic        i_service_instr,
  input  wire logic        i_end_of_init_instr,
  input  wire logic        i_soft_reset_instr,
  input  wire logic        i_disable_instr,
  // reset cause inputs
  input  wire logic        i_core_supply_low,
  input  wire logic        i_long_hw_event,
  input  wire logic        i_short_hw_event,
  input  wire logic        i_bidir_enable,
  input  wire logic        i_reset_in_pin,
  // reset outputs
  output logic             o_hw_reset,
  output logic             o_reset_out_n,
  output logic             o_wdt_running
);

  // state and registers
  wdr_state_t  state_reg;
  wdr_state_t  state_next;
  logic [7:0]  seq_reg;
  logic [7:0]  seq_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [7:0]  reload_reg;
  logic [7:0]  reload_next;
  logic        presc_reg;
  logic        presc_next;
  logic        enabled_reg;
  logic        enabled_next;
  logic        init_done_reg;
  logic        init_done_next;
  logic        supply_low_reg;
  logic [4:0]  flag_reg;
  logic [4:0]  flag_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        hw_reset_reg;
  logic        running_reg;
  logic        reset_out_n_reg;

  // decoded events
  logic        in_run;
  logic        in_reset;
  logic        tick;
  logic        pon_event;
  logic        hw_event;
  logic        service_ok;
  logic        end_of_init_instr_ok;
  logic        soft_ok;
  logic        disable_ok;
  logic        overflow;
  logic        seq_start;
  logic        seq_end;
  logic        promote;
  logic        ctrl_wr;
  logic [4:0]  flag_set;
  logic [4:0]  flag_clr;
  logic [15:0] ctrl_view;
  logic [15:0] stat_view;
  logic [15:0] count_inc;

  assign in_run   = (state_reg == WDR_ST_RUN);
  assign in_reset = (state_reg == WDR_ST_RESET);

  // prescaler is cleared on service and held while the chip is in reset,
  // so a service always starts a whole number of prescaler periods
  wdr_prescaler u_prescaler (
    .i_clock  (i_clock),
    .i_sys_rst(i_sys_rst),
    .i_clear  (service_ok | in_reset),
    .i_div128 (presc_reg),
    .o_tick   (tick)
  );

  // power-on is the rising of the core supply after it fell below threshold;
  // a dip that never crosses it produces no event here and the outside
  // reset logic reports only a long reset
  assign pon_event  = supply_low_reg & ~i_core_supply_low;
  assign hw_event   = pon_event | i_long_hw_event | i_short_hw_event;

  // instructions only count while the cpu is running
  assign service_ok = in_run & i_service_instr;
  assign end_of_init_instr_ok   = in_run & i_end_of_init_instr;
  assign soft_ok    = in_run & i_soft_reset_instr;
  assign disable_ok = in_run & i_disable_instr & ~init_done_reg;

  // overflow when the counter wraps past all ones on a tick
  assign overflow   = in_run & enabled_reg & tick
                      & (count_reg == WDR_COUNT_MAX);

  // internal reset sequence start and end
  assign seq_start  = overflow | soft_ok | hw_event;
  assign seq_end    = in_reset & (seq_reg == WDR_SEQ_LAST) & ~hw_event;

  // bidirectional reset: pin still low at the end turns it into a long reset
  assign promote    = seq_end & i_bidir_enable & ~i_reset_in_pin;

  // software write decode; only the reload and prescale fields are stored
  assign ctrl_wr    = in_run & i_wr & (i_addr == WDR_CTRL_ADDR);

  // flag set groups per reset source
  assign flag_set =
      (pon_event          ? WDR_SET_PON   : WDR_MASK_NONE)
    | (i_long_hw_event    ? WDR_SET_LONG  : WDR_MASK_NONE)
    | (i_short_hw_event   ? WDR_SET_SHORT : WDR_MASK_NONE)
    | (soft_ok            ? WDR_SET_SOFT  : WDR_MASK_NONE)
    | (overflow           ? WDR_SET_WDOG  : WDR_MASK_NONE)
    | (promote            ? WDR_SET_LONG  : WDR_MASK_NONE);

  // flag clear causes; bus writes are deliberately absent here
  assign flag_clr =
      (end_of_init_instr_ok           ? WDR_CLR_END_OF_INIT_INSTR : WDR_MASK_NONE)
    | ((service_ok | hw_event | promote)
                          ? WDR_CLR_OVF   : WDR_MASK_NONE);

  // per-flag next value: a set in the same cycle as a clear wins
  genvar g;
  generate
    for (g = 0; g < WDR_NUM_FLAGS; g = g + 1) begin : g_flag
      assign flag_next[g] = flag_set[g] | (flag_reg[g] & ~flag_clr[g]);
    end
  endgenerate

  // control fields return to defaults whenever the chip is in reset, which
  // gives reload zero at divide by 2, a 131072-clock timeout, until software programs them
  assign reload_next = (seq_start | in_reset) ? WDR_RELOAD_RST
                     : ctrl_wr ? i_wdata[WDR_RELOAD_MSB:WDR_RELOAD_LSB]
                     : reload_reg;
  assign presc_next  = (seq_start | in_reset) ? WDR_PRESC_RST
                     : ctrl_wr ? i_wdata[WDR_PRESC_BIT]
                     : presc_reg;

  // watchdog is re-armed by every reset; disable only before end-of-init
  assign enabled_next   = (seq_start | in_reset) ? 1'b1
                        : disable_ok ? 1'b0
                        : enabled_reg;
  assign init_done_next = (seq_start | in_reset) ? 1'b0
                        : end_of_init_instr_ok ? 1'b1
                        : init_done_reg;

  // counter: service reloads high byte and clears low byte, tick advances;
  // overflow wraps to zero but the reset sequence then takes over anyway
  assign count_inc  = count_reg + WDR_COUNT_ONE;
  assign count_next = (seq_start | in_reset) ? WDR_COUNT_RST
                    : service_ok ? {reload_reg, WDR_LOW_CLR}
                    : (enabled_reg & tick) ? count_inc
                    : count_reg;

  // reset sequence counter and state
  assign seq_next   = seq_start ? WDR_SEQ_RST
                    : in_reset ? seq_reg + WDR_SEQ_ONE
                    : seq_reg;
  assign state_next = seq_start ? WDR_ST_RESET
                    : seq_end ? WDR_ST_RUN
                    : state_reg;

  // read views; reserved bits 7:6 read zero
  assign ctrl_view  = {reload_reg, WDR_CTRL_PAD, flag_reg, presc_reg};
  assign stat_view  = {WDR_STAT_PAD, init_done_reg, enabled_reg};
  assign rdata_next = ~i_rd ? WDR_RDATA_ZERO
                    : (i_addr == WDR_CTRL_ADDR)  ? ctrl_view
                    : (i_addr == WDR_COUNT_ADDR) ? count_reg
                    : (i_addr == WDR_STAT_ADDR)  ? stat_view
                    : WDR_RDATA_ZERO;

  // sequencer state: leaves run on any reset cause and returns once the
  // sequence counter reaches its last value with no new cause pending
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_reg <= WDR_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // sequence length counter; a fresh cause restarts it from zero so the
  // outside world always sees one full-length reset after the last cause
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      seq_reg <= WDR_SEQ_RST;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // watchdog counter; held at zero while the chip is in reset so that
  // nothing can overflow before software has had a chance to run
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      count_reg <= WDR_COUNT_RST;
    end else begin
      count_reg <= count_next;
    end
  end

  // reload field; zero after reset, which is the longest timeout and so
  // the safest choice for an unprogrammed start-up
  // a write during the internal reset is lost on purpose
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      reload_reg <= WDR_RELOAD_RST;
    end else begin
      reload_reg <= reload_next;
    end
  end

  // prescale select; divide by 2 after reset, the shorter of the two timeout ranges
  // a change takes effect in the divider compare from the cycle after the write, without waiting for a wrap
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      presc_reg <= WDR_PRESC_RST;
    end else begin
      presc_reg <= presc_next;
    end
  end

  // watchdog enable; every chip reset re-arms it, so start-up is
  // always supervised even if the previous program had disabled it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      enabled_reg <= 1'h1;
    end else begin
      enabled_reg <= enabled_next;
    end
  end

  // end-of-init seen; once set, later disable requests are ignored
  // until the next reset of any kind clears it again
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      init_done_reg <= 1'h0;
    end else begin
      init_done_reg <= init_done_next;
    end
  end

  // reset cause flags survive the internal reset they describe, so the
  // restarted software can still read why it was restarted
  // only the chip reset wipes them unconditionally
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      flag_reg <= WDR_FLAGS_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // supply level one cycle back; the power-on cause is its falling edge
  // trade-off: one extra flop for a clean single-cycle event, raised in the cycle the input falls
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      supply_low_reg <= 1'h0;
    end else begin
      supply_low_reg <= i_core_supply_low;
    end
  end

  // read data stands for one cycle only and reads zero otherwise,
  // so a stale value can never be mistaken for a fresh answer
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      rdata_reg <= WDR_RDATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // internal reset output, registered from the sequencer decision so
  // it starts in the cycle after the cause and never glitches
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      hw_reset_reg <= 1'h0;
    end else begin
      hw_reset_reg <= (state_next == WDR_ST_RESET);
    end
  end

  // reset-out pin has its own flop rather than an inverter, so the pin
  // changes only on a clock edge, exactly with the internal reset
  // it idles high and is pulled low for the whole sequence
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      reset_out_n_reg <= 1'h1;
    end else begin
      reset_out_n_reg <= (state_next != WDR_ST_RESET);
    end
  end

  // running indication: enabled and not inside an internal reset
  // high after every chip reset, as the watchdog starts armed
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      running_reg <= 1'h1;
    end else begin
      running_reg <= enabled_next & (state_next == WDR_ST_RUN);
    end
  end

  // every output comes straight from its flop; no gate sits between
  // a register and a pin
  assign o_rdata       = rdata_reg;
  assign o_hw_reset    = hw_reset_reg;
  assign o_reset_out_n = reset_out_n_reg;
  assign o_wdt_running = running_reg;

endmodule : wdr_top

/* shared/wdr_pkg.sv */
// wdr_pkg: constants, register map and state type for the watchdog block
// assumes one 50 MHz clock and a synchronous active-high chip reset
package wdr_pkg;

  // register map (16-bit data, plain strobe port)
  localparam logic [15:0] WDR_CTRL_ADDR   = 16'hFFAE;
  localparam logic [15:0] WDR_COUNT_ADDR  = 16'hFFB0;
  localparam logic [15:0] WDR_STAT_ADDR   = 16'hFFB2;
  localparam logic [15:0] WDR_RDATA_ZERO  = 16'h0000;

  // control register field positions
  localparam int unsigned WDR_RELOAD_MSB  = 15;
  localparam int unsigned WDR_RELOAD_LSB  = 8;
  localparam int unsigned WDR_FLAGS_MSB   = 5;
  localparam int unsigned WDR_FLAGS_LSB   = 1;
  localparam int unsigned WDR_PRESC_BIT   = 0;

  // control reset values
  localparam logic [7:0]  WDR_RELOAD_RST  = 8'h00;
  localparam logic        WDR_PRESC_RST   = 1'h0;
  localparam logic [4:0]  WDR_FLAGS_RST   = 5'h00;

  // flag vector: index 0 overflow, 1 soft, 2 short, 3 long, 4 power-on
  localparam int unsigned WDR_NUM_FLAGS   = 5;
  localparam logic [4:0]  WDR_SET_PON     = 5'h1E;
  localparam logic [4:0]  WDR_SET_LONG    = 5'h0E;
  localparam logic [4:0]  WDR_SET_SHORT   = 5'h06;
  localparam logic [4:0]  WDR_SET_SOFT    = 5'h02;
  localparam logic [4:0]  WDR_SET_WDOG    = 5'h03;
  localparam logic [4:0]  WDR_CLR_END_OF_INIT_INSTR   = 5'h1E;
  localparam logic [4:0]  WDR_CLR_OVF     = 5'h01;
  localparam logic [4:0]  WDR_MASK_NONE   = 5'h00;

  // counter
  localparam logic [15:0] WDR_COUNT_RST   = 16'h0000;
  localparam logic [15:0] WDR_COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] WDR_COUNT_ONE   = 16'h0001;
  localparam logic [7:0]  WDR_LOW_CLR     = 8'h00;

  // prescaler: tick when the masked low bits of the divider are all ones
  localparam logic [6:0]  WDR_PRE_RST     = 7'h00;
  localparam logic [6:0]  WDR_PRE_ONE     = 7'h01;
  localparam logic [6:0]  WDR_PRE_DIV2    = 7'h01;
  localparam logic [6:0]  WDR_PRE_DIV128  = 7'h7F;

  // internal reset sequence length (least time, rounded up)
  localparam int unsigned WDR_CLK_NS      = 20;
  localparam int unsigned WDR_RST_SEQ_NS  = 1000;
  localparam int unsigned WDR_RST_SEQ_CYC =
    (WDR_RST_SEQ_NS + WDR_CLK_NS - 1) / WDR_CLK_NS;
  localparam logic [7:0]  WDR_SEQ_LAST    = 8'(WDR_RST_SEQ_CYC - 1);
  localparam logic [7:0]  WDR_SEQ_RST     = 8'h00;
  localparam logic [7:0]  WDR_SEQ_ONE     = 8'h01;

  // status register layout and control register padding
  localparam logic [13:0] WDR_STAT_PAD    = 14'h0000;
  localparam logic [1:0]  WDR_CTRL_PAD    = 2'h0;

  typedef enum logic [0:0] {
    WDR_ST_RUN   = 1'b0,
    WDR_ST_RESET = 1'b1
  } wdr_state_t;

endpackage : wdr_pkg

/* rtl/wdr_prescaler.sv */
// wdr_prescaler: divide-by-2 or divide-by-128 tick for the watchdog counter
// assumes i_clear is pulsed on every service so the first tick is a full period away
`timescale 1ns/100ps
module wdr_prescaler
  import wdr_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // control
  input  wire logic i_clear,
  input  wire logic i_div128,
  // tick out
  output logic      o_tick
);

  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic [6:0] div_mask;

  // divide selection: a tick every 2 or every 128 clocks
  assign div_mask = i_div128 ? WDR_PRE_DIV128 : WDR_PRE_DIV2;
  assign o_tick   = ~i_clear & ((div_reg & div_mask) == div_mask);
  assign div_next = i_clear ? WDR_PRE_RST : div_reg + WDR_PRE_ONE;

  // free-running divider, restarted on clear
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      div_reg <= WDR_PRE_RST;
    end else begin
      div_reg <= div_next;
    end
  end

endmodule : wdr_prescaler

/* verif/wdr_sva.sv */
// wdr_sva: port-level checks on the watchdog top
// assumes a bind onto wdr_top, one clock domain, synchronous reset
`timescale 1ns/100ps
module wdr_sva
  import wdr_pkg::*;
(
  // clock and reset
  input wire logic        i_clock,
  input wire logic        i_sys_rst,
  // register port
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  // instructions and events
  input wire logic        i_end_of_init_instr,
  input wire logic        i_soft_reset_instr,
  input wire logic        i_disable_instr,
  input wire logic        i_core_supply_low,
  input wire logic        i_long_hw_event,
  input wire logic        i_short_hw_event,
  // reset outputs
  input wire logic        o_hw_reset,
  input wire logic        o_reset_out_n,
  input wire logic        o_wdt_running
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  logic [7:0] seq_cnt;
  logic       fresh;

  // sequence length counter; fresh means no end-of-init or internal reset yet
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      seq_cnt <= 8'h00;
      fresh   <= 1'b1;
    end else begin
      seq_cnt <= o_hw_reset ? seq_cnt + 8'h01 : 8'h00;
      fresh   <= fresh & ~i_end_of_init_instr & ~o_hw_reset;
    end
  end

  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == WDR_RDATA_ZERO)
    else $error("read data not zero outside a read answer");
  a_pin_inverse: assert property (o_reset_out_n == !o_hw_reset)
    else $error("reset-out pin does not mirror internal reset");
  a_seq_min: assert property ($fell(o_hw_reset) |-> seq_cnt >= 8'(WDR_RST_SEQ_CYC))
    else $error("internal reset sequence too short");
  a_soft_starts: assert property (i_soft_reset_instr && !o_hw_reset |=> o_hw_reset)
    else $error("soft reset did not start sequence");
  a_event_starts: assert property (i_long_hw_event || i_short_hw_event |=> o_hw_reset)
    else $error("hardware event did not start sequence");
  a_pon_starts: assert property ($fell(i_core_supply_low) |=> o_hw_reset)
    else $error("power-on event did not start sequence");
  a_run_after_rst: assert property ($fell(i_sys_rst) |-> o_wdt_running)
    else $error("watchdog not running after chip reset");
  a_run_after_seq: assert property ($fell(o_hw_reset) |-> ##[0:1] o_wdt_running)
    else $error("watchdog not running after internal reset");
  a_disable_taken: assert property (i_disable_instr && fresh && !o_hw_reset
    |=> !o_wdt_running)
    else $error("early disable request ignored");

  // main scenarios reached
  c_seq: cover property ($rose(o_hw_reset));
  c_disable: cover property (i_disable_instr && fresh);
  c_pon: cover property ($fell(i_core_supply_low));
endmodule : wdr_sva

/* verif/wdr_tb_top.sv */
// wdr_tb_top: self-checking bench for the watchdog with reset flags
// assumes the bench itself plays the cpu, reset classifier and supply monitor
`timescale 1ns/100ps
module wdr_tb_top;
  import wdr_pkg::*;
  logic        i_clock, i_sys_rst, i_wr, i_rd, sup_low, bidir, pin_in, p;
  logic        o_hw_reset, o_reset_out_n, o_wdt_running;
  logic [15:0] i_addr, i_wdata, o_rdata, d, e;
  logic [7:0]  r;
  logic [5:0]  ev;
  int          n_errors, cmp_count, cyc, n, t;

  wdr_top wdr_top_inst (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_service_instr(ev[0]),
    .i_end_of_init_instr(ev[1]), .i_soft_reset_instr(ev[2]), .i_disable_instr(ev[3]),
    .i_core_supply_low(sup_low), .i_long_hw_event(ev[4]), .i_short_hw_event(ev[5]),
    .i_bidir_enable(bidir), .i_reset_in_pin(pin_in), .o_hw_reset(o_hw_reset),
    .o_reset_out_n(o_reset_out_n), .o_wdt_running(o_wdt_running));

  // 50 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // hang guard: the longest test needs about 50k cycles
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tdone();
    t++;
    $display("test %0d done", t);
  endtask : tdone

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe, so sample it there
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic [15:0] m = 16'hFFFF);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata & m, exp);
  endtask : rd

  task automatic pulse(input int k);
    @(posedge i_clock);
    ev <= 6'(1 << k);
    @(posedge i_clock);
    ev <= 6'h00;
  endtask : pulse

  task automatic do_rst();
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
  endtask : do_rst

  // waits for the internal reset and measures how long it stands
  task automatic wait_seq();
    n = 0;
    #1;
    for (int i = 0; i < 20 && o_hw_reset !== 1'b1; i++) @(posedge i_clock) #1;
    while (o_hw_reset === 1'b1 && n < 300) begin
      @(posedge i_clock);
      #1;
      n++;
    end
    chk(16'(n), 16'(WDR_RST_SEQ_CYC));
  endtask : wait_seq

  // flags 5..1 expected per cause: pon, long, short, soft, soft promoted by pin
  function automatic logic [4:0] flag_exp(input int k);
    case (k)
      0: return 5'h1E;
      1, 4: return 5'h0E;
      2: return 5'h06;
      default: return 5'h02;
    endcase
  endfunction : flag_exp

  initial begin
    {i_wr, i_rd, sup_low, bidir, ev, i_addr, i_wdata} = '0;
    pin_in = 1'b1;
    i_sys_rst = 1'b1;
    void'($urandom(32'hB6610A03));
    repeat (2) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    rd(WDR_CTRL_ADDR, 16'h0000);
    rd(16'h1234, 16'h0000);
    pulse(3);
    #1;
    chk(16'(o_wdt_running), 16'h0000);
    tdone();
    do_rst();
    // flag bits are forced high in writes and must not stick
    for (int k = 0; k < 5; k++) begin
      d = (k == 0) ? 16'hFFFF : 16'($urandom) | 16'h003E;
      wr(WDR_CTRL_ADDR, d);
      rd(WDR_CTRL_ADDR, {d[15:8], 7'h00, d[0]});
    end
    r = 8'($urandom % 255);
    wr(WDR_CTRL_ADDR, {r, 8'h00});
    pulse(0);
    rd(WDR_COUNT_ADDR, {r, 8'h00}, 16'hFFF0);
    tdone();
    // overflow timing, with a mid-way service that must restart the count
    for (int k = 0; k < 3; k++) begin
      r = (k == 0) ? (8'hF8 | 8'($urandom % 8)) : (k == 1) ? 8'hFE : 8'hFF;
      p = (k == 2);
      e = 16'(512 * (1 + 63 * p) * (256 - r));
      do_rst();
      wr(WDR_CTRL_ADDR, {r, 7'h00, p});
      pulse(0);
      repeat (e / 2) @(posedge i_clock);
      wr(WDR_CTRL_ADDR, {r, 7'h00, p});
      pulse(0);
      n = 0;
      while (o_hw_reset !== 1'b1 && n < 40000) begin
        @(posedge i_clock);
        #1;
        n++;
      end
      chk(16'(n), e);
      wait_seq();
      rd(WDR_CTRL_ADDR, 16'h0006);
      pulse(0);
      rd(WDR_CTRL_ADDR, 16'h0004);
      tdone();
    end
    // every reset cause but overflow, then end-of-init clears and locks out disable
    for (int k = 0; k < 5; k++) begin
      do_rst();
      bidir  <= (k == 4);
      pin_in <= (k != 4);
      if (k == 0) begin
        @(posedge i_clock);
        sup_low <= 1'b1;
        @(posedge i_clock);
        sup_low <= 1'b0;
      end else pulse((k == 1) ? 4 : (k == 2) ? 5 : 2);
      wait_seq();
      rd(WDR_CTRL_ADDR, {10'h000, flag_exp(k), 1'b0});
      pin_in <= 1'b1;
      pulse(1);
      rd(WDR_CTRL_ADDR, 16'h0000);
      pulse(3);
      #1;
      chk(16'(o_wdt_running), 16'h0001);
      tdone();
    end
    end_sim();
  end
endmodule : wdr_tb_top

bind wdr_top wdr_sva wdr_sva_inst (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_end_of_init_instr(i_end_of_init_instr), .i_soft_reset_instr(i_soft_reset_instr),
  .i_disable_instr(i_disable_instr), .i_core_supply_low(i_core_supply_low),
  .i_long_hw_event(i_long_hw_event), .i_short_hw_event(i_short_hw_event),
  .o_hw_reset(o_hw_reset), .o_reset_out_n(o_reset_out_n), .o_wdt_running(o_wdt_running));
